/* dcp_pkg.sv */
/*
 dcp_pkg: constants and carriers of the ddr capture phase adjust block.
 assumes nothing beyond a systemverilog compiler.
*/
package dcp_pkg;
	localparam int DCP_DATA_W = 16;
	localparam int DCP_FIFO_DEPTH = 8;
	localparam logic [7:0] DCP_ADDR_PHASE = 8'h0a;
	localparam logic [7:0] DCP_ADDR_STATUS = 8'h0e;
	localparam logic [7:0] DCP_PHASE_RST = 8'h00;
	localparam int DCP_OFS_SIGN = 3;
	localparam int DCP_STAT_LOCK = 7;
	localparam int DCP_STAT_RUN = 0;
	localparam int DCP_STAT_CLKOK = 2;
	// phase in steps of 11.25 degrees: 90 degrees is step 8
	localparam logic [4:0] DCP_NOMINAL_STEP = 5'h08;
	localparam logic [2:0] DCP_MAG_MAX = 3'h6;
	localparam int DCP_LINK_MHZ_MIN = 250;
	localparam int DCP_LINK_MHZ_MAX = 575;
	localparam int DCP_CLK_MHZ = 200;
	// link edges counted per lock window; beats in one window of the system clock
	localparam int DCP_WINDOW_CYC = 64;
	localparam logic [7:0] DCP_WIN_LO = 8'((DCP_LINK_MHZ_MIN * DCP_WINDOW_CYC) / DCP_CLK_MHZ);
	localparam logic [7:0] DCP_WIN_HI = 8'((DCP_LINK_MHZ_MAX * DCP_WINDOW_CYC + DCP_CLK_MHZ - 1) / DCP_CLK_MHZ);
	localparam logic [1:0] DCP_LOCK_WINS = 2'h3;

	typedef struct packed {
		logic [DCP_DATA_W-1:0] first_word;
		logic [DCP_DATA_W-1:0] second_word;
	} dcp_pair_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dcp_reg_req_s;
endpackage : dcp_pkg

/* dcp_fifo.sv */
/*
 dcp_fifo: dual-clock fifo with gray pointers, valid/ready on both sides.
 assumes both resets are applied together.
*/
`timescale 1ns/1ps
`default_nettype none
module dcp_fifo
	import dcp_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
)(
	input wire logic wclk,
	input wire logic wrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic rclk,
	input wire logic rrst,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin_q, wbin_d, wgray_q, rbin_q, rbin_d, rgray_q;
	logic [AW:0] rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;
	logic push, pop;

	assign in_ready = (wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
	assign out_valid = (rgray_q != wg_s2_q);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rbin_q[AW-1:0]];

	always_comb
	begin
		wbin_d = wbin_q + (AW+1)'(push);
		rbin_d = rbin_q + (AW+1)'(pop);
	end

	always_ff @(posedge wclk)
	begin
		if (push)
			mem[wbin_q[AW-1:0]] <= in_data;
	end

	always_ff @(posedge wclk or posedge wrst)
	begin
		if (wrst)
		begin
			wbin_q <= '0;
			wgray_q <= '0;
			rg_s1_q <= '0;
			rg_s2_q <= '0;
		end
		else
		begin
			wbin_q <= wbin_d;
			wgray_q <= wbin_d ^ (wbin_d >> 1);
			rg_s1_q <= rgray_q;
			rg_s2_q <= rg_s1_q;
		end
	end

	always_ff @(posedge rclk or posedge rrst)
	begin
		if (rrst)
		begin
			rbin_q <= '0;
			rgray_q <= '0;
			wg_s1_q <= '0;
			wg_s2_q <= '0;
		end
		else
		begin
			rbin_q <= rbin_d;
			rgray_q <= rbin_d ^ (rbin_d >> 1);
			wg_s1_q <= wgray_q;
			wg_s2_q <= wg_s1_q;
		end
	end
endmodule : dcp_fifo
`default_nettype wire

/* dcp_capture.sv */
/*
 dcp_capture: ddr capture front end; the trimmed phase step reaches the link side but does not move the sampling point.
 assumes the link clock is a 2x oversampled copy of the forwarded clock
 (one link edge per quarter... modelled as phase steps), and a simple
 synchronous register port on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dcp_capture
	import dcp_pkg::*;
#(
	parameter int DATA_W = DCP_DATA_W,
	parameter int FIFO_DEPTH = DCP_FIFO_DEPTH
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic forwarded_data_clock,
	input wire logic [DATA_W-1:0] link_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	output logic sample_valid_q,
	input wire logic sample_ready,
	output logic [DATA_W-1:0] first_sample_q,
	output logic [DATA_W-1:0] second_sample_q
);
	// register side
	logic [7:0] phase_q, phase_d;
	logic [7:0] rdata_d;
	logic upd_tgl_q, upd_tgl_d;
	logic [2:0] mag;
	logic [4:0] step;
	logic [4:0] step_q, step_d;
	logic [7:0] win_q, win_d;
	logic [7:0] edge_cnt_q, edge_cnt_d;
	logic [1:0] good_q, good_d;
	logic locked_q, locked_d;
	logic clkok_q, clkok_d;
	logic lt_s1_q, lt_s2_q, lt_s3_q;
	logic us1_q, us2_q, us3_q;
	logic [4:0] lstep_q, lstep_d;
	logic ltgl_q, ltgl_d;
	logic [DATA_W-1:0] rise_word_q, fall_word_q;
	logic ack_s1_q, ack_s2_q;
	logic [4:0] phase_ctr_q, phase_ctr_d;
	logic push_q, push_d;
	logic [DATA_W-1:0] push_first_q, push_second_q;
	logic [2*DATA_W-1:0] push_data;
	logic fifo_ready;
	logic out_valid;
	logic [2*DATA_W-1:0] out_data;
	logic out_take;
	logic rst_link_s1_q, rst_link_q;

	always_comb
	begin
		mag = phase_q[DCP_OFS_SIGN-1:0];
		if (mag > DCP_MAG_MAX)
			mag = DCP_MAG_MAX;
		if (phase_q[DCP_OFS_SIGN])
			step = DCP_NOMINAL_STEP - 5'(mag);
		else
			step = DCP_NOMINAL_STEP + 5'(mag);
	end

	always_comb
	begin
		phase_d = phase_q;
		upd_tgl_d = upd_tgl_q;
		step_d = step_q;
		rdata_d = reg_rdata_q;
		if (reg_wr && reg_addr == DCP_ADDR_PHASE)
		begin
			phase_d = reg_wdata;
			// magnitude 7 is out of range, kept as 6
			if (reg_wdata[DCP_OFS_SIGN-1:0] > DCP_MAG_MAX)
				phase_d[DCP_OFS_SIGN-1:0] = DCP_MAG_MAX;
		end
		// one update in flight: step_q holds until the link side echoes the toggle
		if (step != step_q && upd_tgl_q == ack_s2_q)
		begin
			// step registered in the same cycle as the toggle; the link side takes it after the toggle syncs, so it sees a stable word
			step_d = step;
			upd_tgl_d = ~upd_tgl_q;
		end
		if (reg_rd)
		begin
			if (reg_addr == DCP_ADDR_PHASE)
				rdata_d = phase_q;
			else if (reg_addr == DCP_ADDR_STATUS)
			begin
				rdata_d = '0;
				rdata_d[DCP_STAT_LOCK] = locked_q;
				rdata_d[DCP_STAT_RUN] = ~locked_q;
				rdata_d[DCP_STAT_CLKOK] = clkok_q;
			end
			else
				rdata_d = '0;
		end
	end

	// lock detect: link edges per window must match 250..575 mhz
	always_comb
	begin
		win_d = win_q + 8'h01;
		edge_cnt_d = edge_cnt_q + 8'(lt_s2_q ^ lt_s3_q);
		good_d = good_q;
		locked_d = locked_q;
		clkok_d = clkok_q;
		if (win_q == 8'(DCP_WINDOW_CYC - 1))
		begin
			win_d = '0;
			edge_cnt_d = '0;
			clkok_d = (edge_cnt_q != '0);
			if (edge_cnt_q >= DCP_WIN_LO && edge_cnt_q <= DCP_WIN_HI)
			begin
				if (good_q != DCP_LOCK_WINS)
					good_d = good_q + 2'h1;
				locked_d = (good_q == DCP_LOCK_WINS);
			end
			else
			begin
				good_d = '0;
				locked_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			phase_q <= DCP_PHASE_RST;
			upd_tgl_q <= 1'b0;
			step_q <= DCP_NOMINAL_STEP;
			reg_rdata_q <= '0;
			win_q <= '0;
			edge_cnt_q <= '0;
			good_q <= '0;
			locked_q <= 1'b0;
			clkok_q <= 1'b0;
			lt_s1_q <= 1'b0;
			lt_s2_q <= 1'b0;
			lt_s3_q <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			upd_tgl_q <= upd_tgl_d;
			step_q <= step_d;
			reg_rdata_q <= rdata_d;
			win_q <= win_d;
			edge_cnt_q <= edge_cnt_d;
			good_q <= good_d;
			locked_q <= locked_d;
			clkok_q <= clkok_d;
			lt_s1_q <= ltgl_q;
			lt_s2_q <= lt_s1_q;
			lt_s3_q <= lt_s2_q;
			ack_s1_q <= us3_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	// link domain: reset released synchronously to the link clock
	always_ff @(posedge forwarded_data_clock or posedge rst)
	begin
		if (rst)
		begin
			rst_link_s1_q <= 1'b1;
			rst_link_q <= 1'b1;
		end
		else
		begin
			rst_link_s1_q <= 1'b0;
			rst_link_q <= rst_link_s1_q;
		end
	end

	// internal_sample_clock modelled as a phase counter; words taken when it wraps to zero, every fourth link edge
	always_comb
	begin
		lstep_d = lstep_q;
		ltgl_d = ~ltgl_q;
		phase_ctr_d = phase_ctr_q + 5'h08;
		push_d = 1'b0;
		if (us2_q != us3_q)
			lstep_d = step_q;
		if (phase_ctr_q == '0)
			push_d = fifo_ready;
	end

	// both edges of the link clock capture a word
	always_ff @(posedge forwarded_data_clock)
	begin
		rise_word_q <= link_data;
	end

	always_ff @(negedge forwarded_data_clock)
	begin
		fall_word_q <= link_data;
	end

	always_ff @(posedge forwarded_data_clock or posedge rst_link_q)
	begin
		if (rst_link_q)
		begin
			us1_q <= 1'b0;
			us2_q <= 1'b0;
			us3_q <= 1'b0;
			lstep_q <= DCP_NOMINAL_STEP;
			ltgl_q <= 1'b0;
			phase_ctr_q <= '0;
			push_q <= 1'b0;
			push_first_q <= '0;
			push_second_q <= '0;
		end
		else
		begin
			us1_q <= upd_tgl_q;
			us2_q <= us1_q;
			us3_q <= us2_q;
			lstep_q <= lstep_d;
			ltgl_q <= ltgl_d;
			phase_ctr_q <= phase_ctr_d;
			push_q <= push_d;
			// a pair is a rising word and the falling word that follows it
			push_first_q <= rise_word_q;
			push_second_q <= fall_word_q;
		end
	end

	assign push_data = {push_first_q, push_second_q};

	dcp_fifo #(
		.WIDTH(2*DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.wclk(forwarded_data_clock),
		.wrst(rst_link_q),
		.in_valid(push_q),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.rclk(clk),
		.rrst(rst),
		.out_valid(out_valid),
		.out_ready(out_take),
		.out_data(out_data)
	);

	// output stage drains fifo only when the consumer has room
	assign out_take = out_valid && (!sample_valid_q || sample_ready);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sample_valid_q <= 1'b0;
			first_sample_q <= '0;
			second_sample_q <= '0;
		end
		else
		begin
			if (out_take)
			begin
				sample_valid_q <= 1'b1;
				first_sample_q <= out_data[2*DATA_W-1:DATA_W];
				second_sample_q <= out_data[DATA_W-1:0];
			end
			else if (sample_ready)
				sample_valid_q <= 1'b0;
		end
	end
endmodule : dcp_capture
`default_nettype wire

/* dcp_capture_props.sv */
/*
 port checker of dcp_capture.
 assumes a bind from the bench top.
*/
`timescale 1ns/1ps
`default_nettype none
module dcp_capture_props
	import dcp_pkg::*;
#(
	parameter int DATA_W = DCP_DATA_W
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic sample_valid_q,
	input wire logic sample_ready,
	input wire logic [DATA_W-1:0] first_sample_q,
	input wire logic [DATA_W-1:0] second_sample_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence rd_phase;
		reg_rd && reg_addr == DCP_ADDR_PHASE;
	endsequence
	sequence rd_stat;
		reg_rd && reg_addr == DCP_ADDR_STATUS;
	endsequence
	sequence wr_phase;
		reg_wr && reg_addr == DCP_ADDR_PHASE && reg_wdata[2:0] != 3'h7;
	endsequence
	chk_unmapped_zero: assert property (reg_rd && reg_addr != DCP_ADDR_PHASE && reg_addr != DCP_ADDR_STATUS |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
	chk_status_run_lock: assert property (rd_stat |=> reg_rdata_q[7] != reg_rdata_q[0]) else $error("run and lock agree");
	chk_lock_clock_seen: assert property (rd_stat |=> !reg_rdata_q[7] || reg_rdata_q[2]) else $error("lock without clock");
	chk_mag_clamped: assert property (rd_phase |=> reg_rdata_q[2:0] <= DCP_MAG_MAX) else $error("magnitude above six");
	chk_write_readback: assert property (wr_phase ##1 rd_phase |=> reg_rdata_q == $past(reg_wdata, 2)) else $error("phase readback wrong");
	chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q)) else $error("read data moved");
	chk_valid_holds: assert property (sample_valid_q && !sample_ready |=> sample_valid_q) else $error("valid dropped");
	chk_pair_holds: assert property (sample_valid_q && !sample_ready |=> $stable({first_sample_q, second_sample_q})) else $error("pair moved");
	chk_fall_on_ready: assert property ($fell(sample_valid_q) |-> $past(sample_ready)) else $error("valid fell unread");
endmodule : dcp_capture_props
`default_nettype wire

/* dcp_host_model.sv */
/*
 host model: free running forwarded clock, data moves with each edge.
 assumes nothing of the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module dcp_host_model (
	output logic forwarded_data_clock,
	output logic [15:0] link_data
);
	logic [7:0] cnt;
	initial
	begin
		forwarded_data_clock = 1'b0;
		cnt = 8'h00;
		link_data = 16'h0000;
		#13.7;
		forever
		begin
			#32;
			cnt = cnt + 8'h01;
			// data and clock move in one step, data first so capture never races it
			// top bit marks the edge kind so pairing shows at the far side
			link_data = {forwarded_data_clock, 7'h2a, cnt};
			forwarded_data_clock = ~forwarded_data_clock;
		end
	end
endmodule : dcp_host_model
`default_nettype wire

/* tb_dcp_capture.sv */
/*
 bench of dcp_capture: register accesses, status, stalled stream.
 assumes the host model and the props checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dcp_capture;
	import dcp_pkg::*;
	logic clk, rst, forwarded_data_clock, reg_wr, reg_rd, sample_ready, pend_q;
	logic [15:0] link_data, first_sample_q, second_sample_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, v, e, exp_e;
	logic sample_valid_q, take_q;
	logic [15:0] fs_q, ss_q;
	logic [7:0] exp_q[$];
	int bad_count, comparisons, pairs;
	int seed = 32'h6beee5bb;
	always #2.5 clk = ~clk;
	dcp_host_model dcp_host_model_i (
		.forwarded_data_clock(forwarded_data_clock),
		.link_data(link_data)
	);
	dcp_capture dcp_capture_i (
		.clk(clk),
		.rst(rst),
		.forwarded_data_clock(forwarded_data_clock),
		.link_data(link_data),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q),
		.sample_valid_q(sample_valid_q),
		.sample_ready(sample_ready),
		.first_sample_q(first_sample_q),
		.second_sample_q(second_sample_q)
	);
	task chk(input string what, input logic [15:0] ex, input logic [15:0] got);
		comparisons++;
		if (got !== ex)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, ex, got);
		end
	endtask : chk
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] ex);
		@(negedge clk);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		if (!w)
			exp_q.push_back(ex);
	endtask : acc
	task idle;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask : idle
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// handshake taken as the design saw it, before its outputs move
	always @(posedge clk)
	begin
		pend_q <= reg_rd;
		take_q <= sample_valid_q && sample_ready;
		fs_q <= first_sample_q;
		ss_q <= second_sample_q;
	end
	always @(negedge clk)
	begin
		if (pend_q === 1'b1 && exp_q.size() > 0)
		begin
			exp_e = exp_q.pop_front();
			chk("reg_rdata_q", {8'h00, exp_e}, {8'h00, reg_rdata_q});
		end
		if (take_q === 1'b1)
		begin
			pairs++;
			chk("first_sample_q", {1'b0, 7'h2a, 8'h00}, {fs_q[15:8], 8'h00});
			chk("second_sample_q", {1'b1, 7'h2a, fs_q[7:0] + 8'h01}, ss_q);
		end
	end
	initial
	begin
		#60000;
		bad_count++;
		end_of_test();
	end
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		{reg_wr, reg_rd, sample_ready, reg_addr, reg_wdata} = '0;
		// longer than 19 cycles: the link side needs three of its edges
		repeat (24) @(negedge clk);
		rst = 1'b0;
		acc(1'b0, DCP_ADDR_PHASE, 8'h00, DCP_PHASE_RST);
		acc(1'b1, 8'h33, 8'hff, 8'h00);
		acc(1'b0, 8'h33, 8'h00, 8'h00);
		for (int i = 0; i < 16; i++)
		begin
			v = 8'($random(seed));
			v[3:0] = 4'(i);
			e = v;
			if (v[2:0] == 3'h7)
				e[2:0] = DCP_MAG_MAX;
			acc(1'b1, DCP_ADDR_PHASE, v, 8'h00);
			acc(1'b0, DCP_ADDR_PHASE, 8'h00, e);
		end
		idle();
		$display("test registers done");
		repeat (800) @(negedge clk);
		// 15.6 mhz link is below the lock range
		acc(1'b0, DCP_ADDR_STATUS, 8'h00, 8'h05);
		idle();
		$display("test status done");
		repeat (3000) @(negedge clk) sample_ready = 1'($random(seed));
		sample_ready = 1'b1;
		repeat (200) @(negedge clk);
		chk("pairs seen", 16'h0001, {15'h0000, pairs > 0});
		$display("test stream done");
		end_of_test();
	end
endmodule : tb_dcp_capture
bind dcp_capture dcp_capture_props #(.DATA_W(DATA_W)) dcp_capture_props_i (
	.clk(clk),
	.rst(rst),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata_q(reg_rdata_q),
	.sample_valid_q(sample_valid_q),
	.sample_ready(sample_ready),
	.first_sample_q(first_sample_q),
	.second_sample_q(second_sample_q)
);
`default_nettype wire
